// ---- hw/pmc_pkg.sv ----
// Package for the power mode, wake and reset controller
package pmc_pkg;
  localparam int NSUB = 8;
  localparam int CPU_BIT = 0;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ACT_TPL = 8'h04;
  localparam logic [7:0] OFS_ALT_TPL = 8'h08;
  localparam logic [7:0] OFS_WAKE_EN = 8'h0c;
  localparam logic [7:0] OFS_TW_PER = 8'h10;
  localparam logic [7:0] OFS_WDT = 8'h14;
  localparam logic [7:0] OFS_RST_STAT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Mode command codes in the mode register
  localparam logic [1:0] CMD_ACTIVE = 2'h0;
  localparam logic [1:0] CMD_ALT = 2'h1;
  localparam logic [1:0] CMD_SLEEP = 2'h2;
  localparam logic [1:0] CMD_HIB = 2'h3;
  // Wake enable field positions
  localparam int WK_PERIPH = 0;
  localparam int WK_SUPV = 1;
  localparam int WK_TW = 2;
  localparam int WK_PIN = 3;
  localparam int WK_NUM = 4;
  // Reset status positions
  localparam int RS_EXT_RESET_N = 0;
  localparam int RS_WDT = 1;
  localparam int RS_PRECISE_LOWVOLT_RESET = 2;
  localparam int RS_SUPV = 3;
  localparam int RS_NUM = 4;
  // Reset values
  localparam logic [7:0] ACT_TPL_RST = 8'hff;
  localparam logic [7:0] ALT_TPL_RST = 8'hfc;
  localparam logic [3:0] WAKE_EN_RST = 4'h0;
  localparam logic [15:0] TW_PER_RST = 16'hffff;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SLEEP_RESUME_US = 15;
  localparam int HIB_RESUME_MAX_US = 100;
  localparam int SLEEP_CYC = SLEEP_RESUME_US * CLK_MHZ;
  localparam int HIB_CYC = HIB_RESUME_MAX_US * CLK_MHZ / 2;
  // Global power states
  typedef enum logic [4:0] {
    PMC_ACTIVE = 5'h01,
    PMC_ALT = 5'h02,
    PMC_SLEEP = 5'h04,
    PMC_HIB = 5'h08,
    PMC_RESUME = 5'h10
  } pmc_state_e;
endpackage : pmc_pkg

// ---- hw/pmc_top.sv ----
// Power mode, wake source and reset controller with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_CYC,
  parameter int HIB_CYCLES = HIB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset and wake sources
  input wire logic ext_reset_n,
  input wire logic watchdog_reset,
  input wire logic precise_lowvolt_reset,
  input wire logic periph_irq,
  input wire logic supv_irq,
  input wire logic pin_irq,
  // Outputs
  output logic [NSUB-1:0] sub_clk_en,
  output logic device_reset,
  output logic hib_retain,
  output logic watchdog_en,
  output logic timewheel_irq,
  output logic [4:0] power_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise the external reset pin; reset is taken on the agreed level
  logic [2:0] ext_reset_n_sync_reg;
  logic ext_reset_n_low_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_reset_n_sync_reg <= 3'h7;
      ext_reset_n_low_reg <= 1'b0;
    end else begin
      ext_reset_n_sync_reg <= {ext_reset_n_sync_reg[1:0], ext_reset_n};
      if (ext_reset_n_sync_reg[2] == ext_reset_n_sync_reg[1]) begin
        ext_reset_n_low_reg <= ~ext_reset_n_sync_reg[1];
      end
    end
  end

  // Any device reset source; reinitialises the configuration, timewheel, processor force and power state, but not the status or watchdog enable
  wire dev_rst = ext_reset_n_low_reg | watchdog_reset | precise_lowvolt_reset;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake: take address and data in either order
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;

  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  wire aw_now = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
  wire w_now = w_hold_reg | (s_axi_wvalid & s_axi_wready);
  wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = aw_now & w_now & ~bvalid_reg;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_lane1 = wr_fire & wr_strb[1];
  wire wr_mode = wr_lane0 & (wr_addr == OFS_MODE);
  wire wr_act = wr_lane0 & (wr_addr == OFS_ACT_TPL);
  wire wr_alt = wr_lane0 & (wr_addr == OFS_ALT_TPL);
  wire wr_wken = wr_lane0 & (wr_addr == OFS_WAKE_EN);
  wire wr_tw_lo = wr_lane0 & (wr_addr == OFS_TW_PER);
  wire wr_tw_hi = wr_lane1 & (wr_addr == OFS_TW_PER);
  wire wr_wdt = wr_lane0 & (wr_addr == OFS_WDT);
  wire wr_mapped = (wr_addr[7:2] <= OFS_STATUS[7:2]) & (wr_addr[1:0] == 2'h0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; device reset restores them to defaults, except the watchdog enable
  logic [NSUB-1:0] act_tpl_reg, alt_tpl_reg;
  logic [WK_NUM-1:0] wake_en_reg;
  logic [15:0] tw_per_reg;
  logic [1:0] mode_cmd_reg;
  logic mode_go_reg;
  logic wdt_en_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_tpl_reg <= ACT_TPL_RST;
      alt_tpl_reg <= ALT_TPL_RST;
      wake_en_reg <= WAKE_EN_RST;
      tw_per_reg <= TW_PER_RST;
      mode_cmd_reg <= CMD_ACTIVE;
      mode_go_reg <= 1'b0;
    end else if (dev_rst) begin
      act_tpl_reg <= ACT_TPL_RST;
      alt_tpl_reg <= ALT_TPL_RST;
      wake_en_reg <= WAKE_EN_RST;
      tw_per_reg <= TW_PER_RST;
      mode_cmd_reg <= CMD_ACTIVE;
      mode_go_reg <= 1'b0;
    end else begin
      mode_go_reg <= wr_mode;
      if (wr_mode) mode_cmd_reg <= wr_data[1:0];
      if (wr_act) act_tpl_reg <= wr_data[NSUB-1:0];
      if (wr_alt) alt_tpl_reg <= wr_data[NSUB-1:0];
      if (wr_wken) wake_en_reg <= wr_data[WK_NUM-1:0];
      if (wr_tw_lo) tw_per_reg[7:0] <= wr_data[7:0];
      if (wr_tw_hi) tw_per_reg[15:8] <= wr_data[15:8];
    end
  end

  // Watchdog enable is sticky; only power-on reset clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdt_en_reg <= 1'b0;
    end else if (wr_wdt & wr_data[0]) begin
      wdt_en_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Central timewheel: one-cycle pulse every tw_per_reg + 1 cycles
  logic [15:0] tw_cnt_reg;
  logic tw_pulse_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tw_cnt_reg <= 16'h0;
      tw_pulse_reg <= 1'b0;
    end else if (dev_rst || tw_cnt_reg >= tw_per_reg) begin
      tw_cnt_reg <= 16'h0;
      tw_pulse_reg <= ~dev_rst;
    end else begin
      tw_cnt_reg <= tw_cnt_reg + 16'h1;
      tw_pulse_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification; hibernate passes only the pin interrupt
  pmc_state_e state_reg, state_next;
  wire [WK_NUM-1:0] wk_raw = {pin_irq, tw_pulse_reg, supv_irq, periph_irq};
  wire [WK_NUM-1:0] wk_hib_mask = WK_NUM'(1) << WK_PIN;
  wire in_hib = (state_reg == PMC_HIB);
  wire [WK_NUM-1:0] wk_ok = wk_raw & wake_en_reg
                            & (in_hib ? wk_hib_mask : {WK_NUM{1'b1}});
  wire wk_irq = |wk_ok;
  // Reset events wake too; the reset itself then restores active
  wire wk_rst = watchdog_reset | precise_lowvolt_reset | ext_reset_n_low_reg;

  // Latched wake requests waiting for active mode
  logic wk_pend_reg;
  logic [NSUB-1:0] cpu_force_reg;
  logic [31:0] res_cnt_reg;
  wire res_done = (state_reg == PMC_RESUME) && (res_cnt_reg == 32'h0);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wk_pend_reg <= 1'b0;
    end else if (wk_irq && state_reg == PMC_RESUME) begin
      wk_pend_reg <= 1'b1;
    end else if (state_reg == PMC_ACTIVE) begin
      wk_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global power state machine; boots and resets into active
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMC_ACTIVE, PMC_ALT: begin
        if (mode_go_reg) begin
          case (mode_cmd_reg)
            CMD_ALT: state_next = PMC_ALT;
            CMD_SLEEP: state_next = PMC_SLEEP;
            CMD_HIB: state_next = PMC_HIB;
            default: state_next = PMC_ACTIVE;
          endcase
        end
        if (wk_irq) state_next = PMC_ACTIVE;
      end
      PMC_SLEEP, PMC_HIB: begin
        if (wk_irq) state_next = PMC_RESUME;
      end
      PMC_RESUME: begin
        if (res_done) state_next = PMC_ACTIVE;
      end
      default: state_next = PMC_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= PMC_ACTIVE;
      res_cnt_reg <= 32'h0;
    end else if (wk_rst) begin
      state_reg <= PMC_ACTIVE;
      res_cnt_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == PMC_SLEEP && wk_irq) begin
        res_cnt_reg <= 32'(SLEEP_CYCLES - 1);
      end else if (state_reg == PMC_HIB && wk_irq) begin
        res_cnt_reg <= 32'(HIB_CYCLES - 1);
      end else if (res_cnt_reg != 32'h0) begin
        res_cnt_reg <= res_cnt_reg - 32'h1;
      end
    end
  end

  // Processor forced on from a wakeup until firmware rewrites the template;
  // a wake in the same cycle as the rewrite wins so it is never lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_force_reg <= '0;
    end else if (dev_rst) begin
      cpu_force_reg <= '0;
    end else if (wk_irq || wk_pend_reg || res_done) begin
      cpu_force_reg[CPU_BIT] <= 1'b1;
    end else if (wr_act) begin
      cpu_force_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Subsystem clock enables per state; retention hold in hibernate
  logic [NSUB-1:0] sub_en_reg;
  logic hib_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sub_en_reg <= ACT_TPL_RST;
      hib_reg <= 1'b0;
    end else begin
      hib_reg <= (state_next == PMC_HIB);
      case (state_next)
        PMC_ACTIVE: sub_en_reg <= act_tpl_reg | cpu_force_reg;
        PMC_ALT: sub_en_reg <= alt_tpl_reg | cpu_force_reg;
        default: sub_en_reg <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset status: sticky causes, cleared only by power-on reset
  logic [RS_NUM-1:0] rst_stat_reg;
  wire [RS_NUM-1:0] rs_set = {supv_irq, precise_lowvolt_reset,
                              watchdog_reset, ext_reset_n_low_reg};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_stat_reg <= '0;
    end else begin
      rst_stat_reg <= rst_stat_reg | rs_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; reads never disturb state
  wire [31:0] rd_mux =
    (s_axi_araddr == OFS_MODE) ? {30'h0, mode_cmd_reg} :
    (s_axi_araddr == OFS_ACT_TPL) ? {24'h0, act_tpl_reg} :
    (s_axi_araddr == OFS_ALT_TPL) ? {24'h0, alt_tpl_reg} :
    (s_axi_araddr == OFS_WAKE_EN) ? {28'h0, wake_en_reg} :
    (s_axi_araddr == OFS_TW_PER) ? {16'h0, tw_per_reg} :
    (s_axi_araddr == OFS_WDT) ? {31'h0, wdt_en_reg} :
    (s_axi_araddr == OFS_RST_STAT) ? {28'h0, rst_stat_reg} :
    (s_axi_araddr == OFS_STATUS) ? {19'h0, sub_en_reg, state_reg} : 32'h0;
  wire rd_mapped = (s_axi_araddr[7:2] <= OFS_STATUS[7:2])
                   & (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Outputs
  assign sub_clk_en = sub_en_reg;
  assign device_reset = dev_rst;
  assign hib_retain = hib_reg;
  assign watchdog_en = wdt_en_reg;
  assign timewheel_irq = tw_pulse_reg;
  assign power_state = state_reg;

endmodule : pmc_top

// ---- test/pmc_top_assertions.sv ----
// Assertion checker for the power mode, wake and reset controller
`timescale 1ns/1ps
module pmc_top_assertions
  import pmc_pkg::*;
#(
  parameter int HIB_CYCLES = HIB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reset and wake sources
  input wire logic ext_reset_n,
  input wire logic watchdog_reset,
  input wire logic pin_irq,
  // Controller outputs
  input wire logic [NSUB-1:0] sub_clk_en,
  input wire logic device_reset,
  input wire logic hib_retain,
  input wire logic watchdog_en,
  input wire logic [4:0] power_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles spent resuming; a resume that never ends overflows the bound
  logic [15:0] resume_cnt_reg;
  logic [15:0] resume_cnt_next;
  assign resume_cnt_next = (power_state == PMC_RESUME) ?
                           resume_cnt_reg + 16'h1 : 16'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) resume_cnt_reg <= 16'h0;
    else resume_cnt_reg <= resume_cnt_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Resume just ended
  sequence s_resume_done;
    $past(power_state) == PMC_RESUME && power_state != PMC_RESUME;
  endsequence
  AST_RESUME_EXIT: assert property (s_resume_done |->
    power_state == PMC_ACTIVE) else $error("resume left to a non-active mode");
  AST_WAKE_CPU: assert property (s_resume_done |->
    ##[0:1] sub_clk_en[CPU_BIT]) else $error("cpu not enabled after wake");
  AST_RESUME_BOUND: assert property (
    int'(resume_cnt_reg) <= HIB_CYCLES + 2) else $error("resume too long");
  AST_HIB_RETAIN: assert property (power_state == PMC_HIB |->
    hib_retain) else $error("retention low in hibernate");
  AST_HIB_ONLY_PIN: assert property (
    power_state == PMC_HIB && !pin_irq && !device_reset |=>
    power_state == PMC_HIB) else $error("hibernate left without pin wake");
  AST_DEVRST_ACTIVE: assert property (device_reset |->
    ##[1:2] power_state == PMC_ACTIVE) else $error("reset not to active");
  AST_EXT_RESET_N_HOLD: assert property (!ext_reset_n [*5] |->
    device_reset) else $error("external reset low but no device reset");
  AST_WDT_CAUSE: assert property (watchdog_reset |->
    device_reset ##1 power_state == PMC_ACTIVE)
    else $error("watchdog reset did not wake to active");
  AST_WDT_STICKY: assert property (watchdog_en |=>
    watchdog_en) else $error("watchdog enable cleared");
endmodule : pmc_top_assertions

bind pmc_top pmc_top_assertions #(.HIB_CYCLES(HIB_CYCLES)) i_chk (
  .clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
  .watchdog_reset(watchdog_reset), .pin_irq(pin_irq),
  .sub_clk_en(sub_clk_en), .device_reset(device_reset),
  .hib_retain(hib_retain), .watchdog_en(watchdog_en),
  .power_state(power_state));

// ---- test/tb.sv ----
// Self-checking testbench for the power mode, wake and reset controller
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  // Short resume counts keep the run brief
  localparam int SLP = 20;
  localparam int HIB = 30;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic ext_reset_n = 1'b1, watchdog_reset = 1'b0, pin_irq = 1'b0;
  logic precise_lowvolt_reset = 1'b0, periph_irq = 1'b0, supv_irq = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, device_reset, hib_retain, watchdog_en, timewheel_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] s_axi_rdata, rd;
  logic [NSUB-1:0] sub_clk_en;
  logic [4:0] power_state;
  int num_errors = 0, total_checks = 0, n;
  pmc_top #(.SLEEP_CYCLES(SLP), .HIB_CYCLES(HIB)) i_pmc_top (.*);
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_up(string nm);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", nm);
    final_report();
  endtask : give_up
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles; ready is sampled at the falling edge, where it has settled
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int k;
    logic ta, tw, tb;
    k = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (++k > 50) give_up("write");
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int k;
    logic ta, tb;
    k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (++k > 50) give_up("read");
    end while (!tb);
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic rchk(logic [7:0] a, logic [31:0] e);
    rdr(a, rd, rr);
    chk("rdata", e, rd);
  endtask : rchk
  // Waits for a power state under a bound
  task automatic wait_st(logic [4:0] s, int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      if (++k > lim) give_up("state");
    end while (power_state !== s);
    chk("state", 32'(s), 32'(power_state));
  endtask : wait_st
  // One-cycle pulse on {pin, supv, periph, watchdog, precise}
  task automatic kick(logic [4:0] v);
    @(posedge clk);
    {pin_irq, supv_irq, periph_irq, watchdog_reset,
     precise_lowvolt_reset} <= v;
    @(posedge clk);
    {pin_irq, supv_irq, periph_irq, watchdog_reset,
     precise_lowvolt_reset} <= 5'h0;
  endtask : kick
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    wait_st(PMC_ACTIVE, 2);
    rchk(OFS_ACT_TPL, 32'(ACT_TPL_RST));
    rchk(OFS_ALT_TPL, 32'(ALT_TPL_RST));
    rchk(OFS_WAKE_EN, 32'h0);
    rchk(OFS_RST_STAT, 32'h0);
    rchk(OFS_STATUS, {19'h0, ACT_TPL_RST, PMC_ACTIVE});
    rdr(8'h20, rd, rr);
    chk("rresp", 32'h2, 32'(rr));
    wr(8'h20, 32'h0);
    chk("bresp", 32'h2, 32'(br));
    // Lane 0 alone writes only the low byte of the period
    s_axi_wstrb <= 4'h1;
    wr(OFS_TW_PER, 32'h2210);
    s_axi_wstrb <= 4'hf;
    rchk(OFS_TW_PER, 32'hff10);
    wr(OFS_TW_PER, 32'h10);
    wr(OFS_ACT_TPL, 32'hfe);
    repeat (3) @(negedge clk);
    chk("clk_en", 32'hfe, 32'(sub_clk_en));
    // Sleep, wake by peripheral, second wake while resuming
    wr(OFS_WAKE_EN, 32'h1);
    wr(OFS_MODE, 32'(CMD_SLEEP));
    wait_st(PMC_SLEEP, 4);
    kick(5'h04);
    wait_st(PMC_RESUME, 3);
    kick(5'h04);
    repeat (SLP - 6) @(negedge clk);
    chk("state", 32'(PMC_RESUME), 32'(power_state));
    wait_st(PMC_ACTIVE, 10);
    chk("cpu_en", 32'h1, 32'(sub_clk_en[CPU_BIT]));
    // Alternate active uses its own template
    wr(OFS_MODE, 32'(CMD_ALT));
    wait_st(PMC_ALT, 4);
    @(negedge clk);
    // Processor stays forced on from the last wake until ACT_TPL is written
    chk("clk_en", 32'(ALT_TPL_RST | 8'h01), 32'(sub_clk_en));
    kick(5'h04);
    wait_st(PMC_ACTIVE, 4);
    // The active command also leaves alternate active
    wr(OFS_MODE, 32'(CMD_ALT));
    wait_st(PMC_ALT, 4);
    wr(OFS_MODE, 32'(CMD_ACTIVE));
    wait_st(PMC_ACTIVE, 4);
    // Hibernate ignores all but the pin wake
    // Timewheel left out so a pulse cannot cancel the mode command
    wr(OFS_WAKE_EN, 32'hb);
    wr(OFS_MODE, 32'(CMD_HIB));
    wait_st(PMC_HIB, 4);
    chk("retain", 32'h1, 32'(hib_retain));
    kick(5'h0c);
    repeat (4) @(negedge clk);
    chk("state", 32'(PMC_HIB), 32'(power_state));
    kick(5'h10);
    wait_st(PMC_ACTIVE, HIB + 4);
    rchk(OFS_ACT_TPL, 32'hfe);
    // Timewheel pulse, then timewheel wake from sleep
    n = 0;
    do @(negedge clk); while (timewheel_irq !== 1'b1 && ++n < 70000);
    chk("tw_irq", 32'h1, 32'(timewheel_irq));
    // Enable the timewheel wake only once asleep
    wr(OFS_MODE, 32'(CMD_SLEEP));
    wait_st(PMC_SLEEP, 4);
    wr(OFS_WAKE_EN, 32'h4);
    wait_st(PMC_RESUME, 40);
    wait_st(PMC_ACTIVE, SLP + 4);
    // Watchdog enable is set-only
    wr(OFS_WDT, 32'h1);
    wr(OFS_WDT, 32'h0);
    @(negedge clk);
    chk("wdt_en", 32'h1, 32'(watchdog_en));
    // Reset events wake, reinitialise and are recorded
    wr(OFS_WAKE_EN, 32'h0);
    wr(OFS_MODE, 32'(CMD_SLEEP));
    wait_st(PMC_SLEEP, 4);
    kick(5'h02);
    wait_st(PMC_ACTIVE, SLP + 4);
    rchk(OFS_ACT_TPL, 32'(ACT_TPL_RST));
    @(posedge clk);
    ext_reset_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk("dev_rst", 32'h1, 32'(device_reset));
    @(posedge clk);
    ext_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    kick(5'h01);
    kick(5'h08);
    rchk(OFS_RST_STAT, 32'hf);
    rchk(OFS_RST_STAT, 32'hf);
    chk("wdt_en", 32'h1, 32'(watchdog_en));
    // Power-on reset clears the record and the watchdog enable
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rchk(OFS_RST_STAT, 32'h0);
    chk("wdt_en", 32'h0, 32'(watchdog_en));
    final_report();
  end
endmodule : tb
